/* File: configurable_pin_function_select.sv */
// configurable pin function selector with apb configuration memory
// assumes usb, uart and bit-bang status come from logic on pclk
// Behaviour
// - each pin drives one function chosen by its stored select field
// - after power-on or bus reset the stored selects are loaded
// - transmit-enable option drives low while serial data is sent
// - power-enable low once configured, high again during suspend
// - transmit-activity option pulses low on usb transmit traffic
// - receive-activity option pulses low on usb receive traffic
// - combined-activity option pulses low on traffic either way
// - sleep option low for the whole suspend, high otherwise
// - gpio only on the first four pins, each enabled on its own
// - write-strobe option gives the active-low bit-bang write strobe
// - read-strobe option gives the active-low bit-bang read strobe
// - configuration memory holds 1024 bits
// - fifth pin offers everything but gpio and the two strobes
`timescale 1ns/1ps
`default_nettype none
`include "pin_func_regs.svh"
module configurable_pin_function_select
  import pin_func_pkg::*;
#(
  parameter int LED_PULSE_CYCLES = `LED_PULSE_CYC,
  parameter int LED_W            = 24
) (
  input  wire logic        pclk,             // 200 MHz clock
  input  wire logic        presetn,          // async reset, low
  input  wire logic [11:0] paddr,            // apb byte address
  input  wire logic        psel,             // apb select
  input  wire logic        penable,          // apb access phase
  input  wire logic        pwrite,           // apb write
  input  wire logic [31:0] pwdata,           // apb write data
  input  wire logic [3:0]  pstrb,            // apb byte enables
  output logic      [31:0] prdata,           // apb read data
  output logic             pready,           // apb ready
  output logic             pslverr,          // apb error
  input  wire logic        bus_reset,        // usb bus reset
  input  wire logic        usb_configured,   // host set config
  input  wire logic        usb_suspend,      // bus in suspend
  input  wire logic        serial_tx_busy,   // uart sending
  input  wire logic        usb_tx_activity,  // tx data moved
  input  wire logic        usb_rx_activity,  // rx data moved
  input  wire logic [3:0]  gpio_out,         // bit-bang levels
  input  wire logic [3:0]  gpio_oe_req,      // bit-bang drive
  input  wire logic        bb_write_strobe,  // write strobe
  input  wire logic        bb_read_strobe,   // read strobe
  output logic      [4:0]  configurable_pin_o,  // pin level
  output logic      [4:0]  configurable_pin_oe, // pin drive
  input  wire logic [3:0]  configurable_pin_i,  // pin sense
  output logic      [3:0]  gpio_in           // synced gpio
);

  // refuse pulse lengths the counter cannot hold
  if (LED_PULSE_CYCLES < 1 || LED_PULSE_CYCLES >= 2**LED_W) begin : g_chk
    $error("LED_PULSE_CYCLES out of range");
  end

  localparam logic [LED_W-1:0] LED_LOAD = LED_PULSE_CYCLES[LED_W-1:0];
  localparam logic [`NCO_W-1:0] NCO_STEP = `NCO_W'(`NCO_INC);

  logic [31:0]       cfg_mem [0:`CFG_WORDS-1];
  load_state_t       state, next_state;
  logic [`ACT_W-1:0] active_cfg, next_active_cfg;
  logic [LED_W-1:0]  tx_cnt, next_tx_cnt;
  logic [LED_W-1:0]  rx_cnt, next_rx_cnt;
  logic [`NCO_W-1:0] nco, next_nco;
  logic              sq48_d;
  logic [2:0]        div, next_div;
  logic [3:0]        pin_meta;
  logic [4:0]        next_pin_o, next_pin_oe;
  logic [31:0]       next_prdata;
  logic              next_pready, next_pslverr;
  logic              in_mem, in_active, setup, wr_go;
  logic [31:0]       wr_mask;
  logic [3:0]        gpio_en;

  // apb decode, word aligned, if chain
  always_comb begin
    in_mem    = 1'b0;
    in_active = 1'b0;
    if (paddr[11:`MEM_TOP_LSB] == 5'h00 && paddr[1:0] == 2'h0) begin
      in_mem = 1'b1;
    end else if (paddr == `ACTIVE_ADDR) begin
      in_active = 1'b1;
    end
  end

  // apb answer: ready one cycle after setup, no wait states
  always_comb begin
    setup        = psel & ~penable;
    next_pready  = setup;
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (setup) begin
      if (in_mem) begin
        next_prdata = pwrite ? 32'h0000_0000 : cfg_mem[paddr[6:2]];
      end else if (in_active && !pwrite) begin
        next_prdata = {7'h00, state, active_cfg};
      end else begin
        next_pslverr = 1'b1; // unmapped or read-only
      end
    end
  end

  // apb register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // write commit only at the completing access edge
  always_comb begin
    wr_go   = psel & penable & pready & pwrite & in_mem;
    wr_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  end

  // configuration memory, defaults restored at power-on only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int w = 0; w < `CFG_WORDS; w++) begin
        cfg_mem[w] <= (w == 0) ? `CFG_WORD0_RST : 32'h0000_0000;
      end
    end else if (wr_go) begin
      cfg_mem[paddr[6:2]] <= (cfg_mem[paddr[6:2]] & ~wr_mask) |
                             (pwdata & wr_mask);
    end
  end

  // load the live selection after any reset
  always_comb begin
    next_state      = state;
    next_active_cfg = active_cfg;
    if (bus_reset) begin
      next_state = st_load;
    end else begin
      case (state)
        st_load: begin
          next_active_cfg = cfg_mem[0][`ACT_W-1:0];
          next_state      = st_run;
        end
        st_run: begin
          next_state = st_run;
        end
        default: begin
          next_state = st_load;
        end
      endcase
    end
  end

  // load state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= st_load;
      active_cfg <= `ACT_W'(`CFG_WORD0_RST);
    end else begin
      state      <= next_state;
      active_cfg <= next_active_cfg;
    end
  end

  // activity pulse counters, retriggered by each event
  always_comb begin
    next_tx_cnt = (tx_cnt != '0) ? tx_cnt - 1'b1 : tx_cnt;
    next_rx_cnt = (rx_cnt != '0) ? rx_cnt - 1'b1 : rx_cnt;
    if (usb_tx_activity) begin
      next_tx_cnt = LED_LOAD;
    end
    if (usb_rx_activity) begin
      next_rx_cnt = LED_LOAD;
    end
  end

  // 48 MHz phase accumulator and binary divider below it
  always_comb begin
    next_nco = nco + NCO_STEP;
    next_div = div;
    if (nco[`NCO_W-1] && !sq48_d) begin
      next_div = div + 3'h1;
    end
  end

  // counter and clock registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt <= '0;
      rx_cnt <= '0;
      nco    <= '0;
      sq48_d <= 1'b0;
      div    <= 3'h0;
    end else begin
      tx_cnt <= next_tx_cnt;
      rx_cnt <= next_rx_cnt;
      nco    <= next_nco;
      sq48_d <= nco[`NCO_W-1];
      div    <= next_div;
    end
  end

  // per-function pin levels, active low where named so
  logic rs485_driver_enable_n, power_enable_n, sleep_n;
  logic transmit_activity_led_n, receive_activity_led_n;
  logic any_activity_led_n, gpio_write_strobe_n, gpio_read_strobe_n;
  logic clock_out_48mhz, clock_out_24mhz;
  logic clock_out_12mhz, clock_out_6mhz;
  assign rs485_driver_enable_n   = ~serial_tx_busy;
  assign power_enable_n = ~(usb_configured & ~usb_suspend);
  assign sleep_n                 = ~usb_suspend;
  assign transmit_activity_led_n = (tx_cnt == '0);
  assign receive_activity_led_n  = (rx_cnt == '0);
  assign any_activity_led_n      = (tx_cnt == '0) &&
                                   (rx_cnt == '0);
  assign gpio_write_strobe_n     = ~bb_write_strobe;
  assign gpio_read_strobe_n      = ~bb_read_strobe;
  assign clock_out_48mhz         = nco[`NCO_W-1];
  assign clock_out_24mhz         = div[0];
  assign clock_out_12mhz         = div[1];
  assign clock_out_6mhz          = div[2];
  assign gpio_en = active_cfg[`GPIO_EN_LSB +: 4];

  // pin multiplexer, one function per pin
  always_comb begin
    pin_option_t sel;
    logic        low4;
    sel         = opt_rs485_den;
    low4        = 1'b0;
    next_pin_o  = 5'h1f;
    next_pin_oe = 5'h1f;
    for (int i = 0; i < 5; i++) begin
      sel  = pin_option_t'(active_cfg[i*`SEL_W +: `SEL_W]);
      low4 = (i < 4);
      case (sel)
        opt_rs485_den: next_pin_o[i] = rs485_driver_enable_n;
        opt_power_en:  next_pin_o[i] = power_enable_n;
        opt_tx_led:    next_pin_o[i] = transmit_activity_led_n;
        opt_rx_led:    next_pin_o[i] = receive_activity_led_n;
        opt_any_led:   next_pin_o[i] = any_activity_led_n;
        opt_sleep:     next_pin_o[i] = sleep_n;
        opt_clock_out_48mhz:     next_pin_o[i] = clock_out_48mhz;
        opt_clock_out_24mhz:     next_pin_o[i] = clock_out_24mhz;
        opt_clock_out_12mhz:     next_pin_o[i] = clock_out_12mhz;
        opt_clock_out_6mhz:      next_pin_o[i] = clock_out_6mhz;
        opt_gpio: begin
          if (low4 && gpio_en[i%4]) begin
            next_pin_o[i]  = gpio_out[i%4];
            next_pin_oe[i] = gpio_oe_req[i%4];
          end else if (low4) begin
            next_pin_oe[i] = 1'b0;
          end
        end
        opt_wr_strobe: begin
          if (low4) begin
            next_pin_o[i] = gpio_write_strobe_n;
          end
        end
        opt_rd_strobe: begin
          if (low4) begin
            next_pin_o[i] = gpio_read_strobe_n;
          end
        end
        default: next_pin_o[i] = 1'b1;
      endcase
    end
    if (state == st_load) begin
      next_pin_o  = 5'h1f;
      next_pin_oe = 5'h00;
    end
  end

  // pin output registers and gpio input synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      configurable_pin_o  <= 5'h1f;
      configurable_pin_oe <= 5'h00;
      pin_meta            <= 4'h0;
      gpio_in             <= 4'h0;
    end else begin
      configurable_pin_o  <= next_pin_o;
      configurable_pin_oe <= next_pin_oe;
      pin_meta            <= configurable_pin_i;
      gpio_in             <= pin_meta;
    end
  end

  // checks on loading, the 48 MHz clock, and pin 0 and pin 4 behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  pin_option_t sel0, sel4;
  assign sel0 = pin_option_t'(active_cfg[3:0]);
  assign sel4 = pin_option_t'(active_cfg[19:16]);
  logic run;
  assign run = (state == st_run);

  sequence s_load_step;
    state == st_load && !bus_reset;
  endsequence
  property p_reload;
    s_load_step |=> run &&
      active_cfg == $past(cfg_mem[0][`ACT_W-1:0]);
  endproperty
  a_reload: assert property (p_reload)
    else $error("selection not loaded from memory");
  property p_load_hold;
    bus_reset |=> ##1 configurable_pin_oe == 5'h00;
  endproperty
  a_load_hold: assert property (p_load_hold)
    else $error("pins driven while loading");
  property p_den;
    run && sel0 == opt_rs485_den |=>
      configurable_pin_o[0] == !$past(serial_tx_busy);
  endproperty
  a_den: assert property (p_den)
    else $error("driver enable wrong");
  property p_pwr;
    run && sel0 == opt_power_en && usb_suspend |=>
      configurable_pin_o[0];
  endproperty
  a_pwr: assert property (p_pwr)
    else $error("power enable low in suspend");
  sequence s_tx_hit;
    run && sel0 == opt_tx_led && usb_tx_activity ##1
      sel0 == opt_tx_led;
  endsequence
  property p_tx_led;
    s_tx_hit |=> !configurable_pin_o[0];
  endproperty
  a_tx_led: assert property (p_tx_led)
    else $error("tx led did not pulse");
  property p_rx_idle;
    run && sel0 == opt_rx_led && rx_cnt == '0 |=>
      configurable_pin_o[0];
  endproperty
  a_rx_idle: assert property (p_rx_idle)
    else $error("rx led low while idle");
  property p_any;
    run && sel0 == opt_any_led && (tx_cnt != '0 || rx_cnt != '0)
      |=> !configurable_pin_o[0];
  endproperty
  a_any: assert property (p_any)
    else $error("combined led not low");
  property p_sleep;
    run && sel0 == opt_sleep |=>
      configurable_pin_o[0] == !$past(usb_suspend);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep level wrong");
  property p_clock_out_48mhz;
    nco[`NCO_W-1] |-> ##[1:3] !nco[`NCO_W-1];
  endproperty
  a_clock_out_48mhz: assert property (p_clock_out_48mhz)
    else $error("48 MHz clock stalled");
  property p_gpio_off;
    run && sel0 == opt_gpio && !gpio_en[0] |=>
      !configurable_pin_oe[0];
  endproperty
  a_gpio_off: assert property (p_gpio_off)
    else $error("disabled gpio pin driven");
  property p_wr;
    run && sel0 == opt_wr_strobe |=>
      configurable_pin_o[0] == !$past(bb_write_strobe);
  endproperty
  a_wr: assert property (p_wr)
    else $error("write strobe wrong");
  property p_pin4;
    run && (sel4 == opt_gpio || sel4 == opt_rd_strobe) |=>
      configurable_pin_o[4] && configurable_pin_oe[4];
  endproperty
  a_pin4: assert property (p_pin4)
    else $error("pin 4 offered a gpio function");

endmodule
`default_nettype wire

/* File: configurable_pin_function_select_tb_top.sv */
// self-checking bench for the configurable pin function selector
// assumes the package, header, design and pin_partner compile first
`timescale 1ns/1ps
`default_nettype none
module configurable_pin_function_select_tb_top;
  import pin_func_pkg::*;
  localparam int LED = 12;
  typedef struct {string what; logic [32:0] exp, msk; int kind;} note_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, w;
  logic [3:0]  pstrb, gpio_out, gpio_oe_req, pin_i, gpio_in, ext_en, ext_val;
  logic        bus_reset, usb_configured, usb_suspend, serial_tx_busy;
  logic        tx_act, rx_act, bb_wr, bb_rd, probe, tog_clr, prev0;
  logic [4:0]  pin_o, pin_oe;
  logic [31:0] mem_m [32];
  note_t       q [$];
  int          error_cnt, tests_run, seed, tog_cnt;

  configurable_pin_function_select #(.LED_PULSE_CYCLES(LED), .LED_W(24)) uut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_reset(bus_reset), .usb_configured(usb_configured),
    .usb_suspend(usb_suspend), .serial_tx_busy(serial_tx_busy),
    .usb_tx_activity(tx_act), .usb_rx_activity(rx_act),
    .gpio_out(gpio_out), .gpio_oe_req(gpio_oe_req),
    .bb_write_strobe(bb_wr), .bb_read_strobe(bb_rd),
    .configurable_pin_o(pin_o), .configurable_pin_oe(pin_oe),
    .configurable_pin_i(pin_i), .gpio_in(gpio_in));
  pin_partner far (.pin_o(pin_o), .pin_oe(pin_oe), .ext_en(ext_en),
    .ext_val(ext_val), .pin_i(pin_i));

  // 200 MHz clock
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // overall limit on the run
  initial begin
    repeat (100000) @(posedge pclk);
    error_cnt++;
    print_verdict();
  end

  // monitor: takes the oldest note as each result shows
  always @(posedge pclk) begin
    note_t       n;
    logic [32:0] seen;
    tog_cnt = tog_clr ? 0 : tog_cnt + int'(pin_o[0] !== prev0);
    prev0 = pin_o[0];
    if ((psel && penable && pready) || probe) begin
      n = q.pop_front();
      seen = probe ? {19'h0, gpio_in, pin_oe, pin_o} : {pslverr, prdata};
      if (n.kind == 2)
        seen = 33'(tog_cnt);
      tests_run++;
      if (n.kind == 2 ? (seen + 3 < n.exp || seen > n.exp + 3)
                      : ((seen & n.msk) !== (n.exp & n.msk))) begin
        error_cnt++;
        $display("FAIL %s expected %h seen %h", n.what, n.exp, seen);
      end
    end
  end

  // one apb transfer, held until pready is sampled high
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d,
                     logic [3:0] s, logic [32:0] e);
    int n;
    q.push_back(note_t'{$sformatf("apb %h", a), e,
                  wr ? 33'h1_0000_0000 : {33{1'b1}}, 0});
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!pready && n < 20);
    if (!pready) begin
      error_cnt++;
      print_verdict();
    end
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  // sample pins at the next edge against a note
  task automatic chk(string wh, logic [32:0] e, logic [32:0] m, int k);
    q.push_back(note_t'{wh, e, m, k});
    probe <= 1;
    @(posedge pclk);
    probe <= 0;
    @(posedge pclk);
  endtask

  // expected {oe, o} of one pin for a select code
  function automatic logic [1:0] fexp(logic [3:0] c, logic en, int p);
    case (c)
      4'h0: return {1'b1, ~serial_tx_busy};
      4'h1: return {1'b1, ~(usb_configured & ~usb_suspend)};
      4'h5: return {1'b1, ~usb_suspend};
      4'ha: return p == 4 ? 2'b11 : {gpio_oe_req[0] & en, gpio_out[0]};
      4'hb: return p == 4 ? 2'b11 : {1'b1, ~bb_wr};
      4'hc: return p == 4 ? 2'b11 : {1'b1, ~bb_rd};
      default: return 2'b11;
    endcase
  endfunction

  // main sequence
  initial begin
    logic [3:0]  c4, p4;
    logic [1:0]  e0, e4;
    logic [32:0] e, m;
    logic        g10, en;
    seed = 89851;
    {psel, penable, pwrite, paddr, pwdata, pstrb, bus_reset} = '0;
    {usb_configured, usb_suspend, serial_tx_busy, tx_act, rx_act} = '0;
    {gpio_out, gpio_oe_req, bb_wr, bb_rd, ext_en, ext_val} = '0;
    {probe, tog_clr, prev0, tog_cnt, error_cnt, tests_run} = '0;
    presetn = 0;
    repeat (2) @(posedge pclk);
    chk("reset pins", 33'h1f, {33{1'b1}}, 1);
    presetn <= 1;
    repeat (3) @(posedge pclk);
    apb(0, 12'h080, 0, 4'hf, 33'h0_0105_8321);
    for (int i = 0; i < 32; i++) begin
      mem_m[i] = i == 0 ? 32'h0005_8321 : 32'h0;
      apb(0, 12'(i * 4), 0, 4'hf, {1'b0, mem_m[i]});
    end
    for (int i = 1; i < 32; i++) begin
      w = $random(seed);
      c4 = 4'($random(seed));
      apb(1, 12'(i * 4), w, c4, 33'h0);
      for (int b = 0; b < 4; b++)
        if (c4[b]) mem_m[i][8 * b +: 8] = w[8 * b +: 8];
      apb(0, 12'(i * 4), 0, 4'hf, {1'b0, mem_m[i]});
    end
    apb(0, 12'h084, 0, 4'hf, {1'b1, 32'h0});
    apb(1, 12'h080, 0, 4'hf, {1'b1, 32'h0});
    apb(0, 12'h002, 0, 4'hf, {1'b1, 32'h0});
    $display("test registers done");
    usb_configured <= 1;
    repeat (3) @(posedge pclk);
    chk("configured", 33'h0_1bf6, 33'h0_1ff7, 1);
    usb_suspend <= 1;
    repeat (3) @(posedge pclk);
    chk("suspended", 33'h0_1fe7, 33'h0_1ff7, 1);
    usb_suspend <= 0;
    tx_act <= 1;
    @(posedge pclk);
    tx_act <= 0;
    repeat (2) @(posedge pclk);
    chk("tx led on", 33'h4, 33'h6, 1);
    repeat (LED - 6) @(posedge pclk);
    tx_act <= 1;
    @(posedge pclk);
    tx_act <= 0;
    repeat (LED - 4) @(posedge pclk);
    chk("tx led held", 33'h4, 33'h6, 1);
    repeat (LED + 4) @(posedge pclk);
    chk("leds idle", 33'h6, 33'h7, 1);
    $display("test default pins done");
    for (int c = 0; c < 15; c++) begin
      c4 = c == 13 ? 4'h5 : c == 14 ? 4'ha : 4'(c);
      p4 = c == 13 ? 4'hf : 4'(c);
      w = $random(seed);
      if (c == 10) g10 = w[25];
      en = c == 14 ? ~g10 : w[25];
      {usb_configured, usb_suspend, serial_tx_busy, bb_wr, bb_rd} <= w[4:0];
      {gpio_out, gpio_oe_req, ext_en, ext_val} <= w[20:5];
      apb(1, 12'h000, {11'h0, en, p4, 12'h0, c4}, 4'hf, 33'h0);
      apb(0, 12'h080, 0, 4'hf, {9'h1, mem_m[0][23:0]});
      mem_m[0] = {11'h0, en, p4, 12'h0, c4};
      bus_reset <= 1;
      repeat (2) @(posedge pclk);
      chk("bus reset", 33'h1f, 33'h3ff, 1);
      bus_reset <= 0;
      repeat (4) @(posedge pclk);
      apb(0, 12'h080, 0, 4'hf, {9'h1, mem_m[0][23:0]});
      e0 = fexp(c4, en, 0);
      e4 = fexp(p4, 1'b0, 4);
      e = {19'h0, {3{~serial_tx_busy}}, e0[1] ? e0[0] : ~ext_en[0] |
           ext_val[0], e4[1], 3'h7, e0[1], e4[0], {3{~serial_tx_busy}}, e0[0]};
      m = {33{1'b1}};
      m[0] = !(c4 inside {[6:9]}) && !(c4 == 4'ha && !e0[1]);
      m[10] = !(c4 inside {[6:9]});
      m[4] = !(p4 inside {[6:9]});
      chk($sformatf("select %h", c4), e, m, 1);
      if (c4 inside {[6:9]}) begin
        tog_clr <= 1;
        @(posedge pclk);
        tog_clr <= 0;
        repeat (200) @(posedge pclk);
        chk("clock toggles", 33'(96 >> (c - 6)), 0, 2);
      end
      if (c4 inside {[2:4]}) begin
        rx_act <= 1;
        @(posedge pclk);
        rx_act <= 0;
        repeat (2) @(posedge pclk);
        chk("rx activity", {32'h0, c4 == 4'h2}, 33'h1, 1);
        repeat (LED + 4) @(posedge pclk);
        tx_act <= 1;
        @(posedge pclk);
        tx_act <= 0;
        repeat (2) @(posedge pclk);
        chk("tx activity", {32'h0, c4 == 4'h3}, 33'h1, 1);
        repeat (LED + 4) @(posedge pclk);
      end
    end
    $display("test select codes done");
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: pin_func_pkg.sv */
// types of the configurable pin function selector
// assumes nothing beyond a SystemVerilog compiler
package pin_func_pkg;
  // function choices, one per configurable pin
  typedef enum logic [3:0] {
    opt_rs485_den = 4'h0,
    opt_power_en  = 4'h1,
    opt_tx_led    = 4'h2,
    opt_rx_led    = 4'h3,
    opt_any_led   = 4'h4,
    opt_sleep     = 4'h5,
    opt_clock_out_48mhz     = 4'h6,
    opt_clock_out_24mhz     = 4'h7,
    opt_clock_out_12mhz     = 4'h8,
    opt_clock_out_6mhz      = 4'h9,
    opt_gpio      = 4'ha,
    opt_wr_strobe = 4'hb,
    opt_rd_strobe = 4'hc
  } pin_option_t;
  // load sequence after reset
  typedef enum logic [0:0] {
    st_load = 1'b0,
    st_run  = 1'b1
  } load_state_t;
endpackage

/* File: pin_func_regs.svh */
// constants for the configurable pin function selector
// assumes a 200 MHz pclk and a 32-bit apb register bus
`ifndef PIN_FUNC_REGS_SVH
`define PIN_FUNC_REGS_SVH
// configuration memory, 1024 bits as 32 words
`define CFG_BITS 1024
`define CFG_WORDS 32
`define CFG_IDX_W 5
// word 0 of the memory: pin selects and gpio enables
`define SEL_W 4
`define GPIO_EN_LSB 20
`define ACT_W 24
`define CFG_WORD0_RST 32'h0005_8321
// readback of the live selection, outside the memory
`define ACTIVE_ADDR 12'h080
`define MEM_TOP_LSB 7
// clock output synthesis
`define PCLK_MHZ 200
`define PCLK_NS 5
`define CLOCK_OUT_48MHZ_MHZ 48
`define NCO_W 16
`define NCO_INC ((`CLOCK_OUT_48MHZ_MHZ * 65536) / `PCLK_MHZ)
// activity led pulse, 50 ms
`define LED_PULSE_NS 50000000
`define LED_PULSE_CYC (`LED_PULSE_NS / `PCLK_NS)
`endif

/* File: pin_partner.sv */
// far-side model: pull-ups and an external driver on pins 0..3
// assumes the design drives a pin only while its enable is high
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input  wire logic [4:0] pin_o,   // design level
  input  wire logic [4:0] pin_oe,  // design drive
  input  wire logic [3:0] ext_en,  // far side drives
  input  wire logic [3:0] ext_val, // far side level
  output logic      [3:0] pin_i    // wire level
);
  // a released, undriven wire floats up through its pull-up
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_i[i] = pin_oe[i] ? pin_o[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule
`default_nettype wire
